// ---- design/bstap_pkg.sv ----
// package for the boundary-scan tap controller block
package bstap_pkg;
    localparam int IR_W   = 8;
    localparam int BCC_W  = 38;
    localparam int CTL_W  = 11;
    localparam logic [IR_W-1:0]  IR_RESET    = 8'hff;
    localparam logic [IR_W-1:0]  IR_CAPTURE  = 8'h81;
    localparam logic [BCC_W-1:0] BCC_RESET   = 38'h30_0000_0000;
    localparam logic [CTL_W-1:0] CTL_RESET   = 11'h002;
    localparam logic             BYP_CAPTURE = 1'b0;
    // opcodes, low seven bits; bit 7 is even parity
    localparam logic [6:0] OP_EXTEST  = 7'h00;
    localparam logic [6:0] OP_SAMPLE  = 7'h02;
    localparam logic [6:0] OP_INTEST  = 7'h03;
    localparam logic [6:0] OP_HIGHZ   = 7'h06;
    localparam logic [6:0] OP_CLAMP   = 7'h07;
    localparam logic [6:0] OP_RUNT    = 7'h09;
    localparam logic [6:0] OP_READBN  = 7'h0a;
    localparam logic [6:0] OP_READBT  = 7'h0b;
    localparam logic [6:0] OP_CELLTST = 7'h0c;
    localparam logic [6:0] OP_TOPHIP  = 7'h0d;
    localparam logic [6:0] OP_SCANCN  = 7'h0e;

    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
        ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
        ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } bstap_state_t;

    typedef enum logic [1:0] {
        SEL_BYPASS, SEL_CELLS, SEL_CONTROL
    } bstap_sel_t;

    // decoded instruction
    typedef struct packed {
        bstap_sel_t sel;
        logic       test_mode;
        logic       run_enable;
        logic       update_cells;
    } bstap_dec_t;

    // pin samples through two flops
    typedef struct packed {
        logic [1:0] tck;
        logic [1:0] tms;
        logic [1:0] tdi;
        logic       tck_last;
    } bstap_sync_t;

    typedef struct packed {
        bstap_sync_t        sync;
        bstap_state_t       state;
        logic [IR_W-1:0]    ir_shift;
        logic [IR_W-1:0]    ir_latch;
        logic [BCC_W-1:0]   cell_shift;
        logic [BCC_W-1:0]   cell_latch;
        logic [CTL_W-1:0]   ctl_shift;
        logic [CTL_W-1:0]   ctl_latch;
        logic               byp_shift;
        logic               tdo;
        logic               tdo_en;
    } bstap_regs_t;
endpackage

// ---- design/bstap_top.sv ----
// tap controller, instruction chain and data chains of the scan device
`timescale 1ns/1ps
// Notes on behaviour
// (R1) power-up enters test-logic-reset; test logic off, normal function runs
// (R2) tms held high reaches test-logic-reset within five tck cycles
// (R3) reset loads instruction chain with 11111111, the bypass instruction
// (R4) reset clears boundary cell chain except bits 37-36 set to one
// (R5) reset loads boundary control chain with 00000000010
// (R6) master passes run-test/idle before any test operation
// (R7) control-chain test operation runs only while in run-test/idle
// (R8) select states do nothing and leave on the next tck cycle
// (R9) capture-data loads the selected chain on the exiting rising edge
// (R10) shift entry drives chain lsb on tdo from the first falling edge
// (R11) shift on each rising edge after entry, including the exiting edge
// (R12) first falling edge in exit1 puts tdo back to high impedance
// (R13) exit2 back to shift resumes without recapture
// (R14) pause states hold chain contents for any time
// (R15) data latches update on falling edge after update-data entry
// (R16) capture-instruction loads fixed 10000001 on the exiting edge
// (R17) instruction latches update on falling edge after update-instruction
// (R18) eight-bit instruction picks mode, operation, chain and capture source
// (R19) instruction bit 7 is even parity over the opcode
// (R20) unimplemented opcodes decode as bypass
// (R21) chains have shift stage plus latch; bypass has shift stage only
// (R22) state moves on the tms level sampled at each rising tck edge
// (R23) bypass chain captures zero in capture-data
// (R24) sixteen-state graph follows the standard diagram exactly
module bstap_top
    import bstap_pkg::*;
(
    input  wire logic             CLOCK_I,     // system clock, 100 MHz
    input  wire logic             ARST_N_I,    // async reset, active low
    input  wire logic             TCK_I,       // test clock pin
    input  wire logic             TMS_I,       // test mode select pin
    input  wire logic             TDI_I,       // test data in pin
    input  wire logic [BCC_W-1:0] CELL_CAPTURE_I, // pin samples for cells
    output logic                  TDO_O,       // test data out
    output logic                  TDO_OE_O,    // tdo driven when high
    output logic                  TEST_MODE_O, // normal function inhibited
    output logic                  RUN_TEST_O,  // control-chain op running
    output logic [BCC_W-1:0]      CELL_LATCH_O, // boundary cell latches
    output logic [CTL_W-1:0]      CONTROL_O,   // boundary control latches
    output logic [IR_W-1:0]       INSTR_O      // active instruction
);
    bstap_regs_t      r_r;
    bstap_regs_t      r_nxt;
    bstap_dec_t       dec;
    bstap_state_t     nst;
    logic             rise;
    logic             fall;
    logic             tms;
    logic             tdi;
    logic             par_ok;
    logic             dr_lsb;
    logic [BCC_W-1:0] cell_step;
    logic [CTL_W-1:0] ctl_step;
    logic [IR_W-1:0]  ir_step;

    // decode the active instruction; odd parity or unknown code is bypass
    always_comb begin
        dec.sel          = SEL_BYPASS;
        dec.test_mode    = 1'b0;
        dec.run_enable   = 1'b0;
        dec.update_cells = 1'b0;
        if (par_ok) begin                              // [R19]
            unique case (r_r.ir_latch[6:0])            // [R18]
                // boundary scan in test mode, latches follow the scan
                OP_EXTEST, OP_INTEST: begin
                    dec.sel          = SEL_CELLS;
                    dec.test_mode    = 1'b1;
                    dec.update_cells = 1'b1;
                end
                // boundary read in test mode, latches left alone
                OP_READBT: begin
                    dec.sel       = SEL_CELLS;
                    dec.test_mode = 1'b1;
                end
                // sample and self test run in normal mode
                OP_SAMPLE, OP_CELLTST: begin
                    dec.sel          = SEL_CELLS;
                    dec.update_cells = 1'b1;
                end
                // boundary read in normal mode
                OP_READBN: begin
                    dec.sel = SEL_CELLS;
                end
                // output control codes keep the bypass chain
                OP_HIGHZ, OP_CLAMP, OP_TOPHIP: begin
                    dec.test_mode = 1'b1;
                end
                // control-chain operation, runs in run-test/idle
                OP_RUNT: begin
                    dec.test_mode  = 1'b1;
                    dec.run_enable = 1'b1;
                end
                // control chain between tdi and tdo
                OP_SCANCN: begin
                    dec.sel = SEL_CONTROL;
                end
                // anything else scans through bypass
                default: begin
                    dec.sel = SEL_BYPASS;              // [R20]
                end
            endcase
        end
    end

    // next state from tms, standard sixteen-state graph
    always_comb begin
        unique case (r_r.state)                        // [R24]
            ST_RESET: begin
                nst = tms ? ST_RESET : ST_IDLE;
            end
            ST_IDLE: begin
                nst = tms ? ST_SEL_DR : ST_IDLE;
            end
            ST_SEL_DR: begin
                nst = tms ? ST_SEL_IR : ST_CAP_DR;     // [R8]
            end
            ST_CAP_DR: begin
                nst = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            end
            ST_SHIFT_DR: begin
                nst = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            end
            ST_EXIT1_DR: begin
                nst = tms ? ST_UPD_DR : ST_PAUSE_DR;
            end
            ST_PAUSE_DR: begin
                nst = tms ? ST_EXIT2_DR : ST_PAUSE_DR; // [R14]
            end
            ST_EXIT2_DR: begin
                nst = tms ? ST_UPD_DR : ST_SHIFT_DR;   // [R13]
            end
            ST_UPD_DR: begin
                nst = tms ? ST_SEL_DR : ST_IDLE;
            end
            ST_SEL_IR: begin
                nst = tms ? ST_RESET : ST_CAP_IR;      // [R8]
            end
            ST_CAP_IR: begin
                nst = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            end
            ST_SHIFT_IR: begin
                nst = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            end
            ST_EXIT1_IR: begin
                nst = tms ? ST_UPD_IR : ST_PAUSE_IR;
            end
            ST_PAUSE_IR: begin
                nst = tms ? ST_EXIT2_IR : ST_PAUSE_IR; // [R14]
            end
            ST_EXIT2_IR: begin
                nst = tms ? ST_UPD_IR : ST_SHIFT_IR;   // [R13]
            end
            ST_UPD_IR: begin
                nst = tms ? ST_SEL_DR : ST_IDLE;
            end
        endcase
    end

    // edge detection on the synchronised tck, parity of the instruction
    assign rise   = r_r.sync.tck[1] & ~r_r.sync.tck_last;
    assign fall   = ~r_r.sync.tck[1] & r_r.sync.tck_last;
    assign tms    = r_r.sync.tms[1];
    assign tdi    = r_r.sync.tdi[1];
    assign par_ok = ~^r_r.ir_latch;                    // [R19]

    // chain images one shift on, tdi entering at the top
    always_comb begin
        cell_step = {tdi, r_r.cell_shift[BCC_W-1:1]};
        ctl_step  = {tdi, r_r.ctl_shift[CTL_W-1:1]};
        ir_step   = {tdi, r_r.ir_shift[IR_W-1:1]};
    end

    // lsb of the selected data chain, shown on tdo while shifting
    always_comb begin
        unique case (dec.sel)
            SEL_CELLS:   dr_lsb = r_r.cell_shift[0];
            SEL_CONTROL: dr_lsb = r_r.ctl_shift[0];
            default:     dr_lsb = r_r.byp_shift;       // [R21]
        endcase
    end

    // next value of all state
    always_comb begin
        r_nxt = r_r;
        // two-flop samplers on the scan pins, last tck for edges
        r_nxt.sync.tck      = {r_r.sync.tck[0], TCK_I};
        r_nxt.sync.tms      = {r_r.sync.tms[0], TMS_I};
        r_nxt.sync.tdi      = {r_r.sync.tdi[0], TDI_I};
        r_nxt.sync.tck_last = r_r.sync.tck[1];
        // rising tck: state step, capture and shift
        if (rise) begin
            r_nxt.state = nst;                         // [R22] [R2]
            unique case (r_r.state)
                // parallel load of the selected data chain
                ST_CAP_DR: begin                       // [R9]
                    unique case (dec.sel)
                        SEL_CELLS: begin
                            r_nxt.cell_shift = CELL_CAPTURE_I;
                        end
                        SEL_CONTROL: begin
                            r_nxt.ctl_shift = r_r.ctl_latch;
                        end
                        default: begin
                            r_nxt.byp_shift = BYP_CAPTURE; // [R23]
                        end
                    endcase
                end
                // one bit through the selected data chain
                ST_SHIFT_DR: begin                     // [R11]
                    unique case (dec.sel)
                        SEL_CELLS: begin
                            r_nxt.cell_shift = cell_step;
                        end
                        SEL_CONTROL: begin
                            r_nxt.ctl_shift = ctl_step;
                        end
                        default: begin
                            r_nxt.byp_shift = tdi;
                        end
                    endcase
                end
                // fixed status value into the instruction stage
                ST_CAP_IR: begin
                    r_nxt.ir_shift = IR_CAPTURE;       // [R16]
                end
                // one bit through the instruction stage
                ST_SHIFT_IR: begin
                    r_nxt.ir_shift = ir_step;          // [R11]
                end
                // select, exit, pause and update leave the chains alone
                default: ;                             // [R8] [R14]
            endcase
        end
        // falling tck: reset values, tdo and latch updates
        if (fall) begin
            unique case (r_r.state)
                // test logic back to its power-up values
                ST_RESET: begin                        // [R1] [R3] [R4] [R5]
                    r_nxt.ir_shift   = IR_RESET;
                    r_nxt.ir_latch   = IR_RESET;
                    r_nxt.cell_shift = BCC_RESET;
                    r_nxt.cell_latch = BCC_RESET;
                    r_nxt.ctl_shift  = CTL_RESET;
                    r_nxt.ctl_latch  = CTL_RESET;
                    r_nxt.tdo_en     = 1'b0;
                end
                // selected data chain lsb onto tdo
                ST_SHIFT_DR: begin                     // [R10]
                    r_nxt.tdo_en = 1'b1;
                    r_nxt.tdo    = dr_lsb;
                end
                // instruction stage lsb onto tdo
                ST_SHIFT_IR: begin                     // [R10]
                    r_nxt.tdo_en = 1'b1;
                    r_nxt.tdo    = r_r.ir_shift[0];
                end
                // data latches take the shifted value where the code asks
                ST_UPD_DR: begin                       // [R15] [R21]
                    r_nxt.tdo_en = 1'b0;
                    if (dec.sel == SEL_CELLS && dec.update_cells) begin
                        r_nxt.cell_latch = r_r.cell_shift;
                    end
                    if (dec.sel == SEL_CONTROL) begin
                        r_nxt.ctl_latch = r_r.ctl_shift;
                    end
                end
                // new instruction becomes active
                ST_UPD_IR: begin
                    r_nxt.tdo_en   = 1'b0;
                    r_nxt.ir_latch = r_r.ir_shift;     // [R17]
                end
                // every other state leaves tdo undriven
                default: begin
                    r_nxt.tdo_en = 1'b0;               // [R12]
                end
            endcase
        end
    end

    // register all state; power-up is test-logic-reset
    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            r_r <= '{sync: '{tck: 2'h0, tms: 2'h3, tdi: 2'h3,
                             tck_last: 1'b0},
                     state:      ST_RESET,             // [R1]
                     ir_shift:   IR_RESET,
                     ir_latch:   IR_RESET,
                     cell_shift: BCC_RESET,
                     cell_latch: BCC_RESET,
                     ctl_shift:  CTL_RESET,
                     ctl_latch:  CTL_RESET,
                     byp_shift:  1'b0,
                     tdo:        1'b0,
                     tdo_en:     1'b0};
        end else begin
            r_r <= r_nxt;
        end
    end

    // serial output and its enable
    assign TDO_O        = r_r.tdo;
    assign TDO_OE_O     = r_r.tdo_en;
    // mode flags; test mode never shows in test-logic-reset
    assign TEST_MODE_O  = dec.test_mode & (r_r.state != ST_RESET);
    assign RUN_TEST_O   = dec.run_enable & (r_r.state == ST_IDLE); // [R7] [R6]
    // latched chain values
    assign CELL_LATCH_O = r_r.cell_latch;
    assign CONTROL_O    = r_r.ctl_latch;
    assign INSTR_O      = r_r.ir_latch;
endmodule

// ---- tb/bstap_master.sv ----
// test bus master model driving the four-wire scan port
`timescale 1ns/1ps
module bstap_master (
    input  wire logic clk_i,    // system clock
    input  wire logic tdo_i,    // device data out
    input  wire logic tdo_oe_i, // device out enable
    output logic      tck_o,    // test clock
    output logic      tms_o,    // mode select
    output logic      tdi_o     // data in
);
    // idle levels as the pull-ups would give
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
    end
    // one tck cycle: fall with new tms/tdi, sample tdo, rise
    task automatic tick(input logic tms, input logic tdi,
                        output logic tdo, output logic oe);
        @(posedge clk_i);
        tck_o <= 1'b0;
        tms_o <= tms;
        tdi_o <= tdi;
        repeat (6) @(posedge clk_i);
        tdo = tdo_i;
        oe = tdo_oe_i;
        tck_o <= 1'b1;
        repeat (5) @(posedge clk_i);
    endtask
endmodule

// ---- tb/bstap_monitor.sv ----
// port checker for the tap controller block
`timescale 1ns/1ps
module bstap_monitor
    import bstap_pkg::*;
(
    input wire logic             CLOCK_I,      // clock
    input wire logic             ARST_N_I,     // reset
    input wire logic             TCK_I,        // test clock
    input wire logic             TMS_I,        // mode select
    input wire logic             TDO_O,        // data out
    input wire logic             TDO_OE_O,     // out enable
    input wire logic             TEST_MODE_O,  // test mode
    input wire logic             RUN_TEST_O,   // run active
    input wire logic [BCC_W-1:0] CELL_LATCH_O, // cell latches
    input wire logic [CTL_W-1:0] CONTROL_O,    // control latches
    input wire logic [IR_W-1:0]  INSTR_O       // instruction
);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!ARST_N_I);
    logic [2:0] tms_cnt_r;
    // count tck rises seen with tms high, saturating
    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I)
            tms_cnt_r <= 3'h0;
        else if ($rose(TCK_I))
            tms_cnt_r <= !TMS_I ? 3'h0 :
                (tms_cnt_r == 3'h7 ? 3'h7 : tms_cnt_r + 3'h1);
    end
    // everything at its reset value, test logic quiet
    sequence reset_vals;
        INSTR_O == IR_RESET && CONTROL_O == CTL_RESET && !TDO_OE_O &&
        CELL_LATCH_O == BCC_RESET && !TEST_MODE_O && !RUN_TEST_O;
    endsequence
    reset_values_a: assert property ($rose(ARST_N_I) |-> reset_vals)
        else $error("outputs not at reset values after release");
    five_high_a: assert property (
        tms_cnt_r >= 3'h5 && $fell(TCK_I) |-> ##[3:6] reset_vals)
        else $error("tms high did not reach reset state");
    oe_on_fall_a: assert property ($changed(TDO_OE_O) |-> !TCK_I)
        else $error("tdo enable moved outside tck low");
    tdo_hold_a: assert property (TCK_I && TDO_OE_O |-> $stable(TDO_O))
        else $error("tdo moved while tck high");
    instr_on_fall_a: assert property ($changed(INSTR_O) |-> !TCK_I)
        else $error("instruction moved outside tck low");
    latch_on_fall_a: assert property (
        $changed(CONTROL_O) || $changed(CELL_LATCH_O) |-> !TCK_I)
        else $error("data latches moved outside tck low");
    run_idle_a: assert property (
        RUN_TEST_O |-> INSTR_O == {1'b0, OP_RUNT} && !TDO_OE_O)
        else $error("run active without run instruction in idle");
    parity_bypass_a: assert property (
        ^INSTR_O |-> !TEST_MODE_O && !RUN_TEST_O)
        else $error("odd parity instruction not treated as bypass");
endmodule

bind bstap_top bstap_monitor mon (
    .CLOCK_I(CLOCK_I), .ARST_N_I(ARST_N_I), .TCK_I(TCK_I), .TMS_I(TMS_I),
    .TDO_O(TDO_O), .TDO_OE_O(TDO_OE_O), .TEST_MODE_O(TEST_MODE_O),
    .RUN_TEST_O(RUN_TEST_O), .CELL_LATCH_O(CELL_LATCH_O),
    .CONTROL_O(CONTROL_O), .INSTR_O(INSTR_O)
);

// ---- tb/tb_bstap_top.sv ----
// self-checking bench for the tap controller block
`timescale 1ns/1ps
module tb_bstap_top
    import bstap_pkg::*;
;
    logic             clk, arst_n, tck, tms, tdi, tdo, oe, tmode, run;
    logic [BCC_W-1:0] cap, lat, dout;
    logic [CTL_W-1:0] ctl;
    logic [IR_W-1:0]  instr;
    int               miscompares, compares;

    always #5 clk = ~clk;

    bstap_top dut (
        .CLOCK_I(clk), .ARST_N_I(arst_n), .TCK_I(tck), .TMS_I(tms),
        .TDI_I(tdi), .CELL_CAPTURE_I(cap), .TDO_O(tdo), .TDO_OE_O(oe),
        .TEST_MODE_O(tmode), .RUN_TEST_O(run), .CELL_LATCH_O(lat),
        .CONTROL_O(ctl), .INSTR_O(instr)
    );
    bstap_master m (
        .clk_i(clk), .tdo_i(tdo), .tdo_oe_i(oe), .tck_o(tck),
        .tms_o(tms), .tdi_o(tdi)
    );

    task automatic check(input logic [BCC_W-1:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // scan from idle, optional pause halfway, ends back in idle
    task automatic scan(input logic ir, input int n, input logic pause,
                        input logic [BCC_W-1:0] din,
                        output logic [BCC_W-1:0] q);
        logic o, e;
        q = '0;
        m.tick(1'b1, 1'b0, o, e);
        if (ir) m.tick(1'b1, 1'b0, o, e);
        m.tick(1'b0, 1'b0, o, e);
        m.tick(1'b0, 1'b0, o, e);
        check(e, 1'b0);
        for (int i = 0; i < n; i++) begin
            m.tick(i == n - 1 || (pause && i == n / 2 - 1), din[i], o, e);
            q[i] = o;
            check(e, 1'b1);
            if (pause && i == n / 2 - 1) begin
                m.tick(1'b0, 1'b0, o, e);
                check(e, 1'b0);
                m.tick(1'b0, 1'b0, o, e);
                m.tick(1'b1, 1'b0, o, e);
                m.tick(1'b0, 1'b0, o, e);
            end
        end
        m.tick(1'b1, 1'b0, o, e);
        check(e, 1'b0);
        m.tick(1'b0, 1'b0, o, e);
    endtask

    // values straight after release, then into idle
    task automatic t_reset;
        logic o, e;
        check(instr, IR_RESET);
        check(lat, BCC_RESET);
        check(ctl, CTL_RESET);
        check({tmode, oe, run}, 3'h0);
        m.tick(1'b0, 1'b0, o, e);
        $display("test reset done");
    endtask

    // paused instruction scan, then sample and update the cells
    task automatic t_sample;
        scan(1'b1, IR_W, 1'b1, {1'b1, OP_SAMPLE}, dout);
        check(dout, IR_CAPTURE);
        check(instr, {1'b1, OP_SAMPLE});
        scan(1'b0, BCC_W, 1'b0, 38'h15_0f0f_3c3c, dout);
        check(dout, cap);
        check(lat, 38'h15_0f0f_3c3c);
        $display("test sample done");
    endtask

    // control chain, run in idle, then tms high back to reset
    task automatic t_control;
        logic o, e;
        scan(1'b1, IR_W, 1'b0, {1'b1, OP_SCANCN}, dout);
        scan(1'b0, CTL_W, 1'b1, 11'h5a3, dout);
        check(dout, CTL_RESET);
        check(ctl, 11'h5a3);
        scan(1'b1, IR_W, 1'b0, {1'b0, OP_RUNT}, dout);
        check(run, 1'b1);
        check(tmode, 1'b1);
        m.tick(1'b1, 1'b0, o, e);
        check(run, 1'b0);
        repeat (5) m.tick(1'b1, 1'b0, o, e);
        m.tick(1'b0, 1'b0, o, e);
        check(instr, IR_RESET);
        check(ctl, CTL_RESET);
        check(lat, BCC_RESET);
        $display("test control done");
    endtask

    // odd parity falls back to bypass, which captures zero
    task automatic t_bypass;
        scan(1'b1, IR_W, 1'b0, 8'h80, dout);
        check(tmode, 1'b0);
        scan(1'b0, 2, 1'b0, 2'h1, dout);
        check(dout, 2'h2);
        $display("test bypass done");
    endtask

    task automatic test_done;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // reset, then the scenarios in order
    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        cap = 38'h2a_c3c3_5a5a;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_sample();
        t_control();
        t_bypass();
        test_done();
    end
endmodule
